// ---- rtl/smb_dev.sv ----
// Slave end: byte read/write register port with strapped address.
// Assumes a register bank on clk answering reg_rdata combinationally.
//
// Notes on behaviour
// - Enable strap high: answer default address
// - Enable strap low: select pin picks address
// - Sample enable strap once after power up
// - Lock address on first matching transaction
// - Select mode takes over two fan pins
// - Slave only; write and read byte
// - Seven-bit address, register byte, data byte
// - Every byte travels MSB first
// - Write: three bytes, each acknowledged, stop
// - Read: repeated start, one byte, host nacks
// - Repeated start after command means read
// - Only complete valid writes update registers
// - Bad address or protocol: nack, idle
// - Alert response address only while alerting
// - Undefined reads give zero, writes ignored; reg_wr still strobes for undefined writes
// - General call never acknowledged
// - Clock low too long aborts transfer
// - Never drive clock; tolerate stretching
// - Start then stop resets to idle
// - Alert needs enable bit and event
// - Alert reply carries own address high
// - Alert reply clears the enable bit
`timescale 1ns/100ps
`include "smb_regs.svh"
module smb_dev #(
   parameter int TMO_CYC = `SMB_TMO_MIN_MS * `SMB_CLK_KHZ
) (
   input wire logic clk,
   input wire logic rst_b,
   smb_if.dev bus,
   input wire logic addr_enable_b,
   input wire logic addr_select,
   input wire logic event_active,
   input wire logic alert_irq_enable_bit,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_defined,
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic irq_en_clr,
   output logic fan_pins_disabled,
   output logic [6:0] slave_addr
);
   localparam int TW = $clog2(TMO_CYC + 1);
   localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);
   localparam logic [6:0] SEL_BASE = `SMB_ADDR_SEL_BASE;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic scl_m, scl_q, scl_d, sda_m, sda_q, sda_d;
   logic aen_m, aen_q, asel_m, asel_q;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         {scl_m, scl_q, scl_d} <= 3'h7;
         {sda_m, sda_q, sda_d} <= 3'h7;
         {aen_m, aen_q, asel_m, asel_q} <= 4'hf;
      end
      else
      begin
         {scl_m, scl_q, scl_d} <= {bus.scl, scl_m, scl_q};
         {sda_m, sda_q, sda_d} <= {bus.sda, sda_m, sda_q};
         {aen_m, aen_q} <= {addr_enable_b, aen_m};
         {asel_m, asel_q} <= {addr_select, asel_m};
      end
   end

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_q & ~scl_d;
   assign scl_fall = ~scl_q & scl_d;
   assign start_c = scl_q & scl_d & sda_d & ~sda_q;
   assign stop_c = scl_q & scl_d & ~sda_d & sda_q;

   // ****************************************
   // Address strapping
   // ****************************************
   logic [1:0] strap_cnt;
   logic strap_done, sel_mode, addr_locked, lock_evt;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         sel_mode <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == `SMB_STRAP_SETTLE)
         begin
            strap_done <= 1'b1;
            sel_mode <= ~aen_q;
         end
      end
   end
   assign fan_pins_disabled = sel_mode;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         slave_addr <= `SMB_ADDR_DEFAULT;
         addr_locked <= 1'b0;
      end
      else if (!addr_locked)
      begin
         slave_addr <= sel_mode ? {SEL_BASE[6:1], asel_q} : `SMB_ADDR_DEFAULT;
         if (lock_evt && sel_mode)
            addr_locked <= 1'b1;
      end
   end

   // ****************************************
   // Clock-low timeout
   // ****************************************
   smb_pkg::smb_dev_state_t state, after_ack;
   logic [TW-1:0] low_cnt;
   logic tmo_hit;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         low_cnt <= '0;
      else if (scl_q || state == smb_pkg::SMB_D_IDLE)
         low_cnt <= '0;
      else if (!tmo_hit)
         low_cnt <= low_cnt + TW'(1);
   end
   assign tmo_hit = low_cnt == TMO_LAST;

   // ****************************************
   // Slave sequencer
   // ****************************************
   logic [7:0] shreg, tx;
   logic [3:0] bitcnt;
   logic cmd_done, wr_ok, alert_live;
   logic [6:0] rx_addr;
   assign rx_addr = shreg[7:1];
   assign alert_live = alert_irq_enable_bit & event_active;
   assign bus.dev_sda_o = 1'b0;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= smb_pkg::SMB_D_IDLE;
         after_ack <= smb_pkg::SMB_D_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         bus.dev_sda_oe <= 1'b0;
         cmd_done <= 1'b0;
         wr_ok <= 1'b0;
         reg_addr <= 8'h00;
         reg_wdata <= 8'h00;
         irq_en_clr <= 1'b0;
         lock_evt <= 1'b0;
      end
      else
      begin
         irq_en_clr <= 1'b0;
         lock_evt <= 1'b0;
         if (tmo_hit)
         begin
            state <= smb_pkg::SMB_D_IDLE;
            bus.dev_sda_oe <= 1'b0;
            cmd_done <= 1'b0;
            wr_ok <= 1'b0;
         end
         else if (start_c)
         begin
            state <= smb_pkg::SMB_D_ADDR;
            bitcnt <= 4'h0;
            bus.dev_sda_oe <= 1'b0;
            wr_ok <= 1'b0;
         end
         else if (stop_c)
         begin
            state <= smb_pkg::SMB_D_IDLE;
            bus.dev_sda_oe <= 1'b0;
            cmd_done <= 1'b0;
            wr_ok <= 1'b0;
         end
         else
         begin
            unique case (state)
               smb_pkg::SMB_D_IDLE:
               begin
               end
               smb_pkg::SMB_D_HOLD:
               begin
                  if (scl_fall)
                     wr_ok <= 1'b0;
               end
               smb_pkg::SMB_D_ADDR, smb_pkg::SMB_D_CMD, smb_pkg::SMB_D_DATA:
               begin
                  if (scl_rise)
                  begin
                     shreg <= {shreg[6:0], sda_q};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && bitcnt == 4'h8)
                  begin
                     bitcnt <= 4'h0;
                     state <= smb_pkg::SMB_D_ACK;
                     bus.dev_sda_oe <= 1'b1;
                     if (state == smb_pkg::SMB_D_CMD)
                     begin
                        reg_addr <= shreg;
                        cmd_done <= 1'b1;
                        after_ack <= smb_pkg::SMB_D_DATA;
                     end
                     else if (state == smb_pkg::SMB_D_DATA)
                     begin
                        reg_wdata <= shreg;
                        wr_ok <= 1'b1;
                        cmd_done <= 1'b0;
                        after_ack <= smb_pkg::SMB_D_HOLD;
                     end
                     else if (rx_addr == slave_addr && !shreg[0] && !cmd_done)
                     begin
                        lock_evt <= 1'b1;
                        after_ack <= smb_pkg::SMB_D_CMD;
                     end
                     else if (rx_addr == slave_addr && shreg[0] && cmd_done)
                     begin
                        lock_evt <= 1'b1;
                        cmd_done <= 1'b0;
                        tx <= reg_defined ? reg_rdata : `SMB_UNDEF_DATA;
                        after_ack <= smb_pkg::SMB_D_SEND;
                     end
                     else if (rx_addr == `SMB_ADDR_ARA && shreg[0] && alert_live)
                     begin
                        tx <= {slave_addr, 1'b0};
                        irq_en_clr <= 1'b1;
                        after_ack <= smb_pkg::SMB_D_SEND;
                     end
                     else
                     begin
                        state <= smb_pkg::SMB_D_IDLE;
                        bus.dev_sda_oe <= 1'b0;
                        cmd_done <= 1'b0;
                     end
                  end
               end
               smb_pkg::SMB_D_ACK:
               begin
                  if (scl_fall)
                  begin
                     state <= after_ack;
                     bitcnt <= 4'h0;
                     bus.dev_sda_oe <= (after_ack == smb_pkg::SMB_D_SEND) ? ~tx[7] : 1'b0;
                  end
               end
               smb_pkg::SMB_D_SEND:
               begin
                  if (scl_fall && bitcnt == 4'h7)
                  begin
                     bus.dev_sda_oe <= 1'b0;
                     state <= smb_pkg::SMB_D_HOLD;
                  end
                  else if (scl_fall)
                  begin
                     tx <= {tx[6:0], 1'b0};
                     bus.dev_sda_oe <= ~tx[6];
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // Register write strobe
   // ****************************************
   // strobe on stop of valid write
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         reg_wr <= 1'b0;
      else
         reg_wr <= stop_c & wr_ok & ~tmo_hit;
   end
endmodule : smb_dev

// ---- rtl/smb_regs.svh ----
// Constants of the serial management slave port and its host end.
// Assumes a 100 MHz core clock on both ends.
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH
// ****************************************
// Addresses
// ****************************************
`define SMB_ADDR_DEFAULT 7'h2e
`define SMB_ADDR_SEL_BASE 7'h2c
`define SMB_ADDR_ARA 7'h0c
`define SMB_ADDR_GCALL 7'h00
`define SMB_ADDR_PREFIX_MSB 6
`define SMB_ADDR_PREFIX_LSB 2
`define SMB_UNDEF_DATA 8'h00
// ****************************************
// Timing
// ****************************************
`define SMB_CLK_KHZ 100000
`define SMB_TMO_MIN_MS 25
`define SMB_TMO_MAX_MS 35
`define SMB_SCL_KHZ 100
`define SMB_STRAP_SETTLE 2'h2
`endif

// ---- rtl/smb_pkg.sv ----
// Types shared by both ends of the serial management link.
// Assumes smb_regs.svh supplies the numeric constants.
package smb_pkg;
   typedef enum logic [2:0] {
      SMB_D_IDLE, SMB_D_ADDR, SMB_D_CMD, SMB_D_DATA, SMB_D_ACK, SMB_D_SEND, SMB_D_HOLD
   } smb_dev_state_t;
   typedef enum logic [1:0] {
      SMB_H_IDLE, SMB_H_START, SMB_H_BIT, SMB_H_STOP
   } smb_host_state_t;
endpackage : smb_pkg

// ---- rtl/smb_if.sv ----
// Open-drain clock and data wires joining host and device ends.
// Assumes both lines are pulled up; a driver only ever pulls low.
`timescale 1ns/100ps
interface smb_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Wired-and of every enabled driver over a pull-up
   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o,
      output host_sda_oe);
endinterface : smb_if

// ---- rtl/smb_host.sv ----
// Host end: issues one write-byte or read-byte transfer per request.
// Assumes a single master; clock divided down from clk.
`timescale 1ns/100ps
`include "smb_regs.svh"
module smb_host #(
   parameter int QTR_CYC = `SMB_CLK_KHZ / (4 * `SMB_SCL_KHZ)
) (
   input wire logic clk,
   input wire logic rst_b,
   smb_if.host bus,
   input wire logic req,
   input wire logic req_read,
   input wire logic [6:0] req_addr,
   input wire logic [7:0] req_reg,
   input wire logic [7:0] req_wdata,
   output logic busy,
   output logic done,
   output logic nacked,
   output logic [7:0] rdata
);
   localparam int QW = $clog2(QTR_CYC + 1);
   localparam logic [QW-1:0] Q_LAST = QW'(QTR_CYC - 1);

   // ****************************************
   // Line synchronisers
   // ****************************************
   logic scl_m, scl_q, sda_m, sda_q;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         {scl_m, scl_q, sda_m, sda_q} <= 4'hf;
      else
         {scl_m, scl_q, sda_m, sda_q} <= {bus.scl, scl_m, bus.sda, sda_m};
   end

   // ****************************************
   // Quarter-bit divider
   // ****************************************
   smb_pkg::smb_host_state_t state;
   logic [QW-1:0] qcnt;
   logic [1:0] qph;
   logic tick, stall;
   // Stretching: hold the high phase until the line is seen high
   assign stall = qph == 2'h2 && !scl_q;
   assign tick = qcnt == Q_LAST && !stall;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         qcnt <= '0;
      else if (state == smb_pkg::SMB_H_IDLE || qcnt == Q_LAST)
         qcnt <= stall ? qcnt : '0;
      else
         qcnt <= qcnt + QW'(1);
   end

   // ****************************************
   // Transfer sequencer
   // ****************************************
   logic [2:0] step;
   logic [3:0] bitn;
   logic [8:0] txs, rxs;
   logic rd, busy_q;
   logic [6:0] addr;
   logic [7:0] rg, wd;
   assign bus.host_scl_o = 1'b0;
   assign bus.host_sda_o = 1'b0;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= smb_pkg::SMB_H_IDLE;
         qph <= 2'h0;
         step <= 3'h0;
         bitn <= 4'h0;
         txs <= 9'h1ff;
         rxs <= 9'h000;
         rd <= 1'b0;
         addr <= 7'h00;
         rg <= 8'h00;
         wd <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         nacked <= 1'b0;
         rdata <= 8'h00;
         bus.host_scl_oe <= 1'b0;
         bus.host_sda_oe <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (state == smb_pkg::SMB_H_IDLE)
         begin
            if (req)
            begin
               rd <= req_read;
               addr <= req_addr;
               rg <= req_reg;
               wd <= req_wdata;
               busy <= 1'b1;
               nacked <= 1'b0;
               step <= 3'h0;
               qph <= 2'h0;
               state <= smb_pkg::SMB_H_START;
            end
         end
         else if (tick)
         begin
            qph <= qph + 2'h1;
            unique case (state)
               smb_pkg::SMB_H_START:
               begin
                  unique case (qph)
                     2'h0: bus.host_sda_oe <= 1'b0;
                     2'h1: bus.host_scl_oe <= 1'b0;
                     2'h2: bus.host_sda_oe <= 1'b1;
                     2'h3:
                     begin
                        bus.host_scl_oe <= 1'b1;
                        txs <= {addr, step != 3'h0, 1'b1};
                        bitn <= 4'h0;
                        state <= smb_pkg::SMB_H_BIT;
                     end
                  endcase
               end
               smb_pkg::SMB_H_BIT:
               begin
                  unique case (qph)
                     2'h0: bus.host_sda_oe <= ~txs[8];
                     2'h1: bus.host_scl_oe <= 1'b0;
                     2'h2: rxs <= {rxs[7:0], sda_q};
                     2'h3:
                     begin
                        bus.host_scl_oe <= 1'b1;
                        txs <= {txs[7:0], 1'b1};
                        bitn <= bitn + 4'h1;
                        if (bitn == 4'h8)
                        begin
                           bitn <= 4'h0;
                           if (step == 3'h4)
                           begin
                              rdata <= rxs[8:1];
                              state <= smb_pkg::SMB_H_STOP;
                           end
                           else if (rxs[0])
                           begin
                              nacked <= 1'b1;
                              state <= smb_pkg::SMB_H_STOP;
                           end
                           else if (step == 3'h0)
                           begin
                              step <= 3'h1;
                              txs <= {rg, 1'b1};
                           end
                           else if (step == 3'h1 && rd)
                           begin
                              step <= 3'h3;
                              state <= smb_pkg::SMB_H_START;
                           end
                           else if (step == 3'h1)
                           begin
                              step <= 3'h2;
                              txs <= {wd, 1'b1};
                           end
                           else if (step == 3'h3)
                           begin
                              step <= 3'h4;
                              txs <= 9'h1ff;
                           end
                           else
                              state <= smb_pkg::SMB_H_STOP;
                        end
                     end
                  endcase
               end
               smb_pkg::SMB_H_STOP:
               begin
                  unique case (qph)
                     2'h0: bus.host_sda_oe <= 1'b1;
                     2'h1: bus.host_scl_oe <= 1'b0;
                     2'h2: bus.host_sda_oe <= 1'b0;
                     2'h3:
                     begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= smb_pkg::SMB_H_IDLE;
                     end
                  endcase
               end
            endcase
         end
      end
   end
endmodule : smb_host

// ---- test/smb_checker.sv ----
// Checker: timing relations on the shared link and the device's register side.
// Assumes one clock domain; placed beside the link interface by the bench.
`timescale 1ns/100ps
module smb_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic reg_wr,
   input wire logic fan_pins_disabled,
   input wire logic [6:0] slave_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic sda_q;
   logic [7:0] stop_age;
   logic [7:0] hi_cnt;
   // ****************************************
   // Helpers
   // ****************************************
   always_ff @(posedge clk)
   begin
      sda_q <= sda;
   end
   // Age since the last stop seen on the raw wires
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         stop_age <= 8'hff;
      else if (scl && sda && !sda_q)
         stop_age <= 8'h00;
      else if (stop_age != 8'hff)
         stop_age <= stop_age + 8'h01;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_b || !scl)
         hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hff)
         hi_cnt <= hi_cnt + 8'h01;
   end
   // ****************************************
   // Assertions
   // ****************************************
   // clock from host only
   a_scl_host_only: assert property (scl == !host_scl_oe)
      else $error("clock line not set by host alone");
   a_dev_launch_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device drive began with clock high");
   a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device data moved with clock high");
   a_wr_spacing: assert property (reg_wr |=> !reg_wr [*8])
      else $error("write strobe repeated");
   a_wr_after_stop: assert property (reg_wr |-> stop_age <= 8'h08 && !dev_sda_oe)
      else $error("write strobe without a fresh stop");
   a_addr_legal: assert property (slave_addr inside {7'h2c, 7'h2d, 7'h2e})
      else $error("own address outside strap options");
   // fan pins only in select mode
   a_fan_follows: assert property ($rose(fan_pins_disabled) |-> ##[0:4] slave_addr != 7'h2e)
      else $error("fan pins taken in default mode");
   a_dev_quiet_idle: assert property (hi_cnt > 8'h28 |-> !dev_sda_oe)
      else $error("device drives an idle bus");
   c_write: cover property (reg_wr);
   c_dev_drive: cover property ($rose(dev_sda_oe));
   c_select: cover property ($rose(fan_pins_disabled));
endmodule : smb_checker

// ---- test/tb.sv ----
// Bench: host end talks to device end over one link; bench holds the register bank.
// Assumes the rtl files compile first; shortened link timing.
`timescale 1ns/100ps
module tb;
   logic clk, rst_b, addr_enable_b, addr_select, event_active, alert_irq_enable_bit;
   logic reg_defined, reg_wr, irq_en_clr, fan_pins_disabled, req, req_read, busy, done, nacked;
   logic [7:0] reg_rdata, reg_addr, reg_wdata, req_reg, req_wdata, rdata, addr_byte, shift;
   logic [6:0] slave_addr, req_addr;
   logic [7:0] mem [256];
   int nbits, n_wr, n_fail, n_compared, cyc, n_clr;
   smb_if link ();
   smb_dev #(.TMO_CYC(2000)) smb_dev_inst (.clk(clk), .rst_b(rst_b), .bus(link.dev),
      .addr_enable_b(addr_enable_b), .addr_select(addr_select), .event_active(event_active),
      .alert_irq_enable_bit(alert_irq_enable_bit), .reg_rdata(reg_rdata), .reg_defined(reg_defined),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .irq_en_clr(irq_en_clr),
      .fan_pins_disabled(fan_pins_disabled), .slave_addr(slave_addr));
   smb_host #(.QTR_CYC(4)) smb_host_inst (.clk(clk), .rst_b(rst_b), .bus(link.host), .req(req),
      .req_read(req_read), .req_addr(req_addr), .req_reg(req_reg), .req_wdata(req_wdata),
      .busy(busy), .done(done), .nacked(nacked), .rdata(rdata));
   smb_checker smb_checker_inst (.clk(clk), .rst_b(rst_b), .scl(link.scl), .sda(link.sda),
      .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
      .reg_wr(reg_wr), .fan_pins_disabled(fan_pins_disabled), .slave_addr(slave_addr));
   // ****************************************
   // Bank and link monitor
   // ****************************************
   // Upper half unpopulated; junk there must not reach the link
   assign reg_defined = !reg_addr[7];
   assign reg_rdata = reg_defined ? mem[reg_addr] : 8'hff;
   always @(posedge clk)
   begin
      if (reg_wr === 1'b1 && reg_defined)
      begin
         mem[reg_addr] <= reg_wdata;
         n_wr++;
      end
      if (irq_en_clr === 1'b1)
         n_clr++;
      cyc++;
      if (cyc == 80000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   always @(negedge link.sda)
   begin
      if (link.scl)
         nbits = 0;
   end
   always @(posedge link.scl)
   begin
      shift = {shift[6:0], link.sda};
      nbits++;
      if (nbits == 8)
         addr_byte = shift;
   end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [7:0] exp_own(input logic en_b, input logic sel);
      return en_b ? 8'h2e : {7'h16, sel};
   endfunction : exp_own
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic do_reset(input logic en_b, input logic sel);
      rst_b = 1'b0;
      addr_enable_b = en_b;
      addr_select = sel;
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (8) @(posedge clk);
      #1;
   endtask : do_reset
   task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
      input logic nak, input logic [7:0] exp);
      int w;
      int wr0;
      wr0 = n_wr;
      @(posedge clk);
      #1 req = 1'b1;
      req_read = rd;
      req_addr = a;
      req_reg = r;
      req_wdata = d;
      @(posedge clk);
      #1 req = 1'b0;
      w = 0;
      while (done !== 1'b1 && w < 3000)
      begin
         @(posedge clk);
         #1 w++;
      end
      check("done seen", {7'h00, done}, 8'h01);
      check("nack", {7'h00, nacked}, {7'h00, nak});
      check("address byte", addr_byte, {a, rd && !nak});
      if (rd && !nak)
         check("read data", rdata, exp);
      // Strobe lands a few clocks after stop
      repeat (6) @(posedge clk);
      #1;
      check("write count", 8'(n_wr - wr0), {7'h00, !rd && !nak && !r[7]});
   endtask : xfer
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [7:0] r;
      logic [7:0] d;
      logic [6:0] own;
      logic [6:0] bad [6];
      bad = '{7'h00, 7'h0c, 7'h2c, 7'h2d, 7'h2f, 7'h6e};
      {req, req_read, req_addr, req_reg, req_wdata} = '0;
      {event_active, alert_irq_enable_bit, nbits, n_wr, n_fail, n_compared, cyc, n_clr} = '0;
      void'($urandom(32'h9c96));
      do_reset(1'b1, 1'b0);
      check("own address", {1'b0, slave_addr}, exp_own(1'b1, 1'b0));
      check("fan pins", {7'h00, fan_pins_disabled}, 8'h00);
      for (int i = 0; i < 12; i++)
      begin
         r = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($urandom) & 8'h7f;
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         xfer(1'b0, 7'h2e, r, d, 1'b0, 8'h00);
         xfer(1'b1, 7'h2e, r, 8'h00, 1'b0, d);
      end
      $display("test random access done");
      r = 8'($urandom) | 8'h80;
      xfer(1'b0, 7'h2e, r, 8'h5a, 1'b0, 8'h00);
      xfer(1'b1, 7'h2e, r, 8'h00, 1'b0, 8'h00);
      $display("test undefined register done");
      event_active = 1'b1;
      alert_irq_enable_bit = 1'b1;
      foreach (bad[k])
      begin
         xfer(1'b0, bad[k], 8'h05, 8'h99, 1'b1, 8'h00);
         xfer(1'b1, bad[k], 8'h05, 8'h00, 1'b1, 8'h00);
      end
      check("alert clears", 8'(n_clr), 8'h00);
      $display("test refused address done");
      for (int s = 0; s < 2; s++)
      begin
         do_reset(1'b0, s[0]);
         own = 7'h2c | 7'(s);
         check("own address", {1'b0, slave_addr}, exp_own(1'b0, s[0]));
         check("fan pins", {7'h00, fan_pins_disabled}, 8'h01);
         xfer(1'b0, own ^ 7'h01, 8'h11, 8'h00, 1'b1, 8'h00);
         xfer(1'b0, 7'h2e, 8'h11, 8'h00, 1'b1, 8'h00);
         xfer(1'b0, own, 8'h12, 8'h3c ^ 8'(s), 1'b0, 8'h00);
         addr_select = ~s[0];
         xfer(1'b1, own, 8'h12, 8'h00, 1'b0, 8'h3c ^ 8'(s));
         check("locked address", {1'b0, slave_addr}, {1'b0, own});
      end
      $display("test select mode done");
      give_verdict();
   end
endmodule : tb
